// ==== src/step_profile_defs.vh ====
// Purpose: Shared constants for the step rate profile generator
// Assumes: 100 MHz hclk, 32-bit AHB-Lite register bus
// Notes: Offsets are byte addresses of word registers
`ifndef STEP_PROFILE_DEFS_VH
`define STEP_PROFILE_DEFS_VH

// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_START_SPEED 8'h04
`define OFS_PROG_SPEED  8'h08
`define OFS_ACCEL       8'h0C
`define OFS_DECEL       8'h10
`define OFS_JERK        8'h14
`define OFS_MOVE_LEN    8'h18
`define OFS_STATUS      8'h1C
`define OFS_CUR_SPEED   8'h20
`define OFS_STEP_COUNT  8'h24

// Control bit positions
`define CTRL_START_BIT  0
`define CTRL_STOP_BIT   1

// Status bit positions
`define STAT_BUSY_BIT   0
`define STAT_SCURVE_BIT 1
`define STAT_STATE_LSB  2
`define STAT_DONE_BIT   4

// Field widths
`define SPEED_W         20
`define RAMP_W          16
`define JERK_W          13
`define FRAC_W          16

// Reset values
`define RST_START_SPEED 20'h0008D
`define RST_PROG_SPEED  20'h003E8
`define RST_ACCEL       16'h0014
`define RST_DECEL       16'h0019
`define RST_JERK        13'h0000
`define RST_MOVE_LEN    32'h000003E8

// Jerk limits and scaling
`define JERK_MAX        13'h1388
`define JERK_DIV        100
`define JERK_RECIP      16'hA7C6

// Timing: one profile update per millisecond
`define CLK_PERIOD_NS   10
`define TICK_TIME_NS    1000000
`define TICK_CYCLES     (`TICK_TIME_NS / `CLK_PERIOD_NS)

// Step generator: one step per this many speed units
`define CLK_HZ          32'h05F5E100

`endif

// ==== src/step_pulse_gen.v ====
// Purpose: Turns a speed in steps/s into step pulses
// Assumes: 100 MHz clock, speed well below the clock rate
// Notes: Rate accumulator, pulse output registered
`timescale 1ns/100ps
`include "step_profile_defs.vh"

module step_pulse_gen
(
	input  wire                 hclk,
	input  wire                 hresetn,
	input  wire                 ce,
	input  wire                 run,
	input  wire [`SPEED_W-1:0] speed,
	output reg                  step_pulse
);

	reg  [31:0] rate_acc_reg;
	wire [31:0] rate_sum;

	assign rate_sum = rate_acc_reg + {12'h000, speed};

	// Accumulate speed each cycle, wrap at the clock rate
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rate_acc_reg <= 32'h00000000;
			step_pulse   <= 1'b0;
		end
		else if (ce)
		begin
			if (!run)
			begin
				rate_acc_reg <= 32'h00000000; // Each move starts at a clean phase
				step_pulse   <= 1'b0;
			end
			else if (rate_sum >= `CLK_HZ)
			begin
				rate_acc_reg <= rate_sum - `CLK_HZ;
				step_pulse   <= 1'b1;
			end
			else
			begin
				rate_acc_reg <= rate_sum;
				step_pulse   <= 1'b0;
			end
		end
	end

endmodule // step_pulse_gen

// ==== src/step_rate_profile_generator.v ====
// Purpose: Move profile generator with linear and S-curve ramps
// Assumes: AHB-Lite slave, zero wait states, 1 ms profile update
// Notes: Speeds in steps/s, ramps in steps/ms/s, jerk unitless
`timescale 1ns/100ps
`include "step_profile_defs.vh"

module step_rate_profile_generator
#(
	parameter TICK_CYCLES = `TICK_CYCLES
)
(
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        ce,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	output wire        step_out,
	output reg         moving
);

	localparam ST_IDLE   = 2'b00;
	localparam ST_ACCEL  = 2'b01;
	localparam ST_CRUISE = 2'b10;
	localparam ST_DECEL  = 2'b11;
	localparam SPD_FX_W  = `SPEED_W + `FRAC_W;
	localparam ACC_FX_W  = `RAMP_W + `FRAC_W;

	// Software registers
	reg [`SPEED_W-1:0] start_speed_reg;
	reg [`SPEED_W-1:0] prog_speed_reg;
	reg [`RAMP_W-1:0]  accel_reg;
	reg [`RAMP_W-1:0]  decel_reg;
	reg [`JERK_W-1:0]  jerk_reg;
	reg [31:0]         move_len_reg;
	reg                done_reg;

	// Bus data phase
	reg        wr_pend_reg;
	reg [7:0]  wr_addr_reg;

	// Profile state
	reg [1:0]          state_reg;
	reg [SPD_FX_W-1:0] speed_fx_reg;
	reg [ACC_FX_W-1:0] acc_fx_reg;
	reg [SPD_FX_W-1:0] v_rise_reg;
	reg                rising_reg;
	reg [31:0]         step_cnt_reg;
	reg [31:0]         accel_steps_reg;
	reg [31:0]         tick_cnt_reg;
	reg                start_req;
	reg                stop_req;

	// Jerk increment per ms in fixed point acceleration units
	function [ACC_FX_W-1:0] jerk_inc;
		input [`JERK_W-1:0] j;
		input [`RAMP_W-1:0] a;
		reg   [44:0]        prod;
		begin
			prod     = {32'h00000000, j} * {29'h00000000, a} * {29'h00000000, `JERK_RECIP}; // J*A/100000, 16-bit fraction
			jerk_inc = (prod[44:16] == 29'h00000000) ? 32'h00000001 : {3'b000, prod[44:16]};
		end
	endfunction

	// Clamp jerk field into its legal range
	function [`JERK_W-1:0] jerk_clamp;
		input [31:0] v;
		begin
			jerk_clamp = (v > {19'h00000, `JERK_MAX}) ? `JERK_MAX : v[`JERK_W-1:0];
		end
	endfunction

	wire               addr_ok     = hsel & hready & htrans[1];
	wire               scurve      = (jerk_reg != 13'h0000);
	wire [ACC_FX_W-1:0] acc_lim    = {accel_reg, 16'h0000};
	wire [ACC_FX_W-1:0] dec_lim    = {decel_reg, 16'h0000};
	wire [ACC_FX_W-1:0] acc_inc    = jerk_inc(jerk_reg, accel_reg);
	wire [ACC_FX_W-1:0] dec_inc    = jerk_inc(jerk_reg, decel_reg);
	wire [SPD_FX_W-1:0] vs_fx      = {start_speed_reg, 16'h0000};
	wire [SPD_FX_W-1:0] vp_fx      = {prog_speed_reg, 16'h0000};
	wire [SPD_FX_W-1:0] acc_ext    = {4'h0, acc_fx_reg};
	wire               tick        = (tick_cnt_reg == TICK_CYCLES - 1);
	wire               step_pulse;
	wire [31:0]        steps_left  = move_len_reg - step_cnt_reg;
	wire [47:0]        left_scaled = {16'h0000, steps_left} * {32'h00000000, decel_reg};
	wire [47:0]        used_scaled = {16'h0000, accel_steps_reg} * {32'h00000000, accel_reg};
	wire               turn_down   = (left_scaled <= used_scaled);
	wire               last_step   = step_pulse && (step_cnt_reg + 32'h00000001 >= move_len_reg);

	assign step_out = step_pulse;

	// Address phase: capture write, load read data
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
			hrdata      <= 32'h00000000;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
		end
		else if (ce)
		begin
			hreadyout   <= 1'b1; // Never stalls
			hresp       <= 1'b0; // Always OKAY
			wr_pend_reg <= addr_ok & hwrite;
			wr_addr_reg <= haddr[7:0];
			if (addr_ok & ~hwrite)
			begin
				case (haddr[7:0])
					`OFS_START_SPEED: hrdata <= {12'h000, start_speed_reg};
					`OFS_PROG_SPEED:  hrdata <= {12'h000, prog_speed_reg};
					`OFS_ACCEL:       hrdata <= {16'h0000, accel_reg};
					`OFS_DECEL:       hrdata <= {16'h0000, decel_reg};
					`OFS_JERK:        hrdata <= {19'h00000, jerk_reg};
					`OFS_MOVE_LEN:    hrdata <= move_len_reg;
					`OFS_STATUS:      hrdata <= {27'h0000000, done_reg, state_reg, scurve, moving};
					`OFS_CUR_SPEED:   hrdata <= {12'h000, speed_fx_reg[SPD_FX_W-1:`FRAC_W]};
					`OFS_STEP_COUNT:  hrdata <= step_cnt_reg;
					default:          hrdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Data phase writes; ramps in steps/ms/s as given by host
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			start_speed_reg <= `RST_START_SPEED;
			prog_speed_reg  <= `RST_PROG_SPEED;
			accel_reg       <= `RST_ACCEL;
			decel_reg       <= `RST_DECEL;
			jerk_reg        <= `RST_JERK;
			move_len_reg    <= `RST_MOVE_LEN;
			start_req       <= 1'b0;
			stop_req        <= 1'b0;
		end
		else if (ce)
		begin
			start_req <= 1'b0;
			stop_req  <= 1'b0;
			if (wr_pend_reg)
			begin
				case (wr_addr_reg)
					`OFS_CTRL:
					begin
						start_req <= hwdata[`CTRL_START_BIT];
						stop_req  <= hwdata[`CTRL_STOP_BIT];
					end
					`OFS_START_SPEED: start_speed_reg <= hwdata[`SPEED_W-1:0];
					`OFS_PROG_SPEED:  prog_speed_reg  <= hwdata[`SPEED_W-1:0];
					`OFS_ACCEL:       accel_reg       <= hwdata[`RAMP_W-1:0];
					`OFS_DECEL:       decel_reg       <= hwdata[`RAMP_W-1:0];
					`OFS_JERK:        jerk_reg        <= jerk_clamp(hwdata);
					`OFS_MOVE_LEN:    move_len_reg    <= hwdata;
					default:          ;
				endcase
			end
		end
	end

	// Profile engine: ramps advance once per ms tick, step count every pulse
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg       <= ST_IDLE;
			speed_fx_reg    <= {SPD_FX_W{1'b0}};
			acc_fx_reg      <= {ACC_FX_W{1'b0}};
			v_rise_reg      <= {SPD_FX_W{1'b0}};
			rising_reg      <= 1'b0;
			step_cnt_reg    <= 32'h00000000;
			accel_steps_reg <= 32'h00000000;
			tick_cnt_reg    <= 32'h00000000;
			moving          <= 1'b0;
			done_reg        <= 1'b0;
		end
		else if (ce)
		begin
			tick_cnt_reg <= tick ? 32'h00000000 : tick_cnt_reg + 32'h00000001;
			if (state_reg != ST_IDLE && step_pulse)
			begin
				step_cnt_reg <= step_cnt_reg + 32'h00000001;
				if (state_reg == ST_ACCEL)
					accel_steps_reg <= accel_steps_reg + 32'h00000001;
			end
			case (state_reg)
				ST_IDLE:
				begin
					if (start_req && move_len_reg != 32'h00000000)
					begin
						state_reg       <= ST_ACCEL;
						speed_fx_reg    <= vs_fx;
						acc_fx_reg      <= scurve ? {ACC_FX_W{1'b0}} : acc_lim;
						v_rise_reg      <= {SPD_FX_W{1'b0}};
						rising_reg      <= 1'b1;
						step_cnt_reg    <= 32'h00000000;
						accel_steps_reg <= 32'h00000000;
						tick_cnt_reg    <= 32'h00000000;
						moving          <= 1'b1;
						done_reg        <= 1'b0;
					end
				end
				ST_ACCEL:
				begin
					if (turn_down)
					begin
						// Triangle: no cruise at all
						state_reg  <= ST_DECEL;
						acc_fx_reg <= scurve ? {ACC_FX_W{1'b0}} : dec_lim;
						v_rise_reg <= {SPD_FX_W{1'b0}};
						rising_reg <= 1'b1;
					end
					else if (tick)
					begin
						if (!scurve)
							speed_fx_reg <= speed_fx_reg + acc_ext; // Constant slope
						else
						begin
							speed_fx_reg <= speed_fx_reg + acc_ext;
							if (rising_reg)
							begin
								// Clamp at programmed value gives the plateau
								if (acc_fx_reg + acc_inc >= acc_lim)
									acc_fx_reg <= acc_lim;
								else
								begin
									acc_fx_reg <= acc_fx_reg + acc_inc;
									v_rise_reg <= v_rise_reg + acc_ext;
								end
								// Symmetric ramp: fall once the rise gain covers the rest
								if (vp_fx - speed_fx_reg <= v_rise_reg + acc_ext + acc_ext)
									rising_reg <= 1'b0;
							end
							else if (acc_fx_reg > acc_inc + acc_inc)
								acc_fx_reg <= acc_fx_reg - acc_inc;
							else
								acc_fx_reg <= acc_inc; // Floor keeps the ramp finishing
						end
						if (speed_fx_reg + acc_ext >= vp_fx)
						begin
							speed_fx_reg <= vp_fx;
							state_reg    <= ST_CRUISE;
						end
					end
				end
				ST_CRUISE:
				begin
					// Cruise covers length minus both ramp counts
					if (turn_down)
					begin
						state_reg  <= ST_DECEL;
						acc_fx_reg <= scurve ? {ACC_FX_W{1'b0}} : dec_lim;
						v_rise_reg <= {SPD_FX_W{1'b0}};
						rising_reg <= 1'b1;
					end
				end
				ST_DECEL:
				begin
					if (tick)
					begin
						if (scurve && rising_reg)
						begin
							// Same jerk scaling on the deceleration value
							if (acc_fx_reg + dec_inc >= dec_lim)
								acc_fx_reg <= dec_lim;
							else
							begin
								acc_fx_reg <= acc_fx_reg + dec_inc;
								v_rise_reg <= v_rise_reg + acc_ext;
							end
							if (speed_fx_reg - vs_fx <= v_rise_reg + acc_ext + acc_ext)
								rising_reg <= 1'b0;
						end
						else if (scurve)
							acc_fx_reg <= (acc_fx_reg > dec_inc + dec_inc) ? acc_fx_reg - dec_inc : dec_inc;
						if (speed_fx_reg <= vs_fx + acc_ext)
							speed_fx_reg <= vs_fx; // Tail runs at starting speed
						else
							speed_fx_reg <= speed_fx_reg - acc_ext;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
			// End of move or abort overrides everything
			if (state_reg != ST_IDLE && (last_step || stop_req))
			begin
				state_reg    <= ST_IDLE;
				speed_fx_reg <= {SPD_FX_W{1'b0}};
				moving       <= 1'b0;
				done_reg     <= last_step;
			end
		end
	end

	// Step timing follows the instantaneous speed
	step_pulse_gen u_step
	(
		.hclk       (hclk),
		.hresetn    (hresetn),
		.ce         (ce),
		.run        (moving),
		.speed      (speed_fx_reg[SPD_FX_W-1:`FRAC_W]),
		.step_pulse (step_pulse)
	);

endmodule // step_rate_profile_generator

// ==== verif/profile_checker_assertions.sv ====
// Purpose: Port-level checks for the profile generator
// Assumes: Zero-wait bus slave, one clock domain
// Notes: Move length is snooped from bus writes
`timescale 1ns/100ps
`include "step_profile_defs.vh"
module profile_checker
(
	input wire        hclk,
	input wire        hresetn,
	input wire        ce,
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [31:0] hwdata,
	input wire        hready,
	input wire [31:0] hrdata,
	input wire        hreadyout,
	input wire        hresp,
	input wire        step_out,
	input wire        moving
);
	reg         dp_reg;
	reg         dw_reg;
	reg  [31:0] da_reg;
	reg  [31:0] len_reg;
	reg  [31:0] cnt_reg;
	wire        rd_end = dp_reg && !dw_reg;
	wire        ctrl_end = dp_reg && dw_reg && da_reg == `OFS_CTRL;
	// Data phase tracking and step count; ce gates so a frozen pulse counts once
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_reg <= 1'b0;
			dw_reg <= 1'b0;
			da_reg <= 32'h0;
			len_reg <= `RST_MOVE_LEN;
			cnt_reg <= 32'h0;
		end
		else
		begin
			dp_reg <= hsel && hready && htrans[1] && ce;
			dw_reg <= hwrite;
			da_reg <= haddr;
			if (dp_reg && dw_reg && da_reg == `OFS_MOVE_LEN)
				len_reg <= hwdata;
			if (!moving)
				cnt_reg <= 32'h0;
			else if (step_out && ce)
				cnt_reg <= cnt_reg + 32'h1;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	ready_high_a: assert property (hreadyout) else $error("hreadyout low");
	resp_okay_a: assert property (!hresp) else $error("hresp not OKAY");
	step_pulse_a: assert property (step_out && ce |=> !step_out) else $error("step pulse too long");
	step_in_move_a: assert property (step_out |-> moving || $past(moving)) else $error("step while idle");
	step_bound_a: assert property (step_out && ce |-> cnt_reg < len_reg) else $error("step past length");
	move_end_a: assert property (step_out && ce && moving && cnt_reg == len_reg - 32'h1 |-> ##[1:2] !moving)
		else $error("move not ended at length");
	start_move_a: assert property (ctrl_end && hwdata[0] && !moving && len_reg != 32'h0 && ce
		|-> ##[1:3] moving) else $error("start not taken");
	stop_move_a: assert property (ctrl_end && hwdata[1] && moving && ce |-> ##[1:3] !moving)
		else $error("stop not taken");
	unmapped_zero_a: assert property (rd_end && (da_reg == `OFS_CTRL || da_reg > `OFS_STEP_COUNT) |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	jerk_field_a: assert property (rd_end && da_reg == `OFS_JERK |-> hrdata <= 32'h1388)
		else $error("jerk field out of range");
	cover property (ctrl_end && hwdata[1] && moving);
	cover property (step_out && ce && cnt_reg == len_reg - 32'h1);
	cover property (rd_end && da_reg == `OFS_JERK && hrdata == 32'h1388);
endmodule // profile_checker

// ==== verif/motor_stage_model.sv ====
// Purpose: Motor stage stand-in counting step pulses
// Assumes: Step pulses synchronous to hclk
// Notes: Counts rising edges, as a real stage would, so a held level counts once
`timescale 1ns/100ps
module motor_stage_model
(
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        clear,
	input  wire        step_out,
	output reg  [31:0] steps
);
	reg                prev_reg;
	// Edge counter, cleared by the bench before a move
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			steps <= 32'h0;
			prev_reg <= 1'b0;
		end
		else
		begin
			prev_reg <= step_out;
			if (clear)
				steps <= 32'h0;
			else if (step_out && !prev_reg)
				steps <= steps + 32'h1;
		end
	end
endmodule // motor_stage_model

// ==== verif/step_rate_profile_generator_test.sv ====
// Purpose: Self-checking bench for the profile generator
// Assumes: Zero-wait slave, tick cut to 100 cycles
// Notes: Master waits on hready, never on a fixed count
`timescale 1ns/100ps
`include "step_profile_defs.vh"
module step_rate_profile_generator_test;
	typedef struct packed { logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; } row_t;
	reg         hclk;
	reg         hresetn;
	reg         ce;
	reg         hsel;
	reg  [31:0] haddr;
	reg  [1:0]  htrans;
	reg         hwrite;
	reg  [31:0] hwdata;
	reg         clear;
	wire [31:0] hrdata;
	wire        hreadyout;
	wire        hresp;
	wire        step_out;
	wire        moving;
	wire [31:0] steps;
	integer     n_errors;
	integer     compares;
	integer     i;
	reg  [31:0] q;
	reg  [31:0] s0;
	reg  [31:0] s1;
	reg  [31:0] s2;
	reg         cr;
	row_t       rows [16];
	step_rate_profile_generator #(.TICK_CYCLES(100)) dut_u
	(
		.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .step_out(step_out), .moving(moving)
	);
	motor_stage_model stage_u (.hclk(hclk), .hresetn(hresetn), .clear(clear), .step_out(step_out), .steps(steps));
	// One single transfer; read data taken at the data phase's ready edge
	task bus(input w, input [7:0] a, input [31:0] d);
	begin
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	end
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
	begin
		compares = compares + 1;
		if (g !== e)
		begin
			n_errors = n_errors + 1;
			$display("[FAIL] %0s expected %h seen %h", nm, e, g);
		end
	end
	endtask
	task set_move(input [31:0] vs, input [31:0] vp, input [31:0] acc, input [31:0] j, input [31:0] len);
	begin
		bus(1'b1, `OFS_START_SPEED, vs);
		bus(1'b1, `OFS_PROG_SPEED, vp);
		bus(1'b1, `OFS_ACCEL, acc);
		bus(1'b1, `OFS_DECEL, acc);
		bus(1'b1, `OFS_JERK, j);
		bus(1'b1, `OFS_MOVE_LEN, len);
	end
	endtask
	task go;
	begin
		clear <= 1'b1;
		bus(1'b1, `OFS_CTRL, 32'h1);
		clear <= 1'b0;
		repeat (3) @(posedge hclk);
	end
	endtask
	// Status polling doubles as the wait for the end of a move
	task poll;
	begin
		cr = 1'b0;
		while (moving === 1'b1)
		begin
			bus(1'b0, `OFS_STATUS, 32'h0);
			if (q[3:2] === 2'h2)
				cr = 1'b1;
		end
	end
	endtask
	// Three speed reads exactly ten ticks apart, so tick phase cancels out
	task sample3;
	begin
		repeat (300) @(posedge hclk);
		bus(1'b0, `OFS_CUR_SPEED, 32'h0);
		s0 = q;
		repeat (998) @(posedge hclk);
		bus(1'b0, `OFS_CUR_SPEED, 32'h0);
		s1 = q;
		repeat (998) @(posedge hclk);
		bus(1'b0, `OFS_CUR_SPEED, 32'h0);
		s2 = q;
		bus(1'b1, `OFS_CTRL, 32'h2);
		repeat (3) @(posedge hclk);
		chk("abort moving", 32'h0, {31'h0, moving});
		bus(1'b0, `OFS_STATUS, 32'h0);
		chk("abort done", 32'h0, {31'h0, q[`STAT_DONE_BIT]});
	end
	endtask
	task stop_test;
	begin
		$display("Compares %0d, errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	end
	endtask
	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	// Watchdog, about three times the expected run
	initial
	begin
		#1000000;
		n_errors = n_errors + 1;
		stop_test;
	end
	initial
	begin
		{hresetn, hsel, haddr, htrans, hwrite, hwdata, clear} = 70'h0;
		ce = 1'b1;
		n_errors = 0;
		compares = 0;
		rows = '{'{0, `OFS_START_SPEED, 0, `RST_START_SPEED}, '{0, `OFS_PROG_SPEED, 0, `RST_PROG_SPEED},
			'{0, `OFS_ACCEL, 0, `RST_ACCEL}, '{0, `OFS_DECEL, 0, `RST_DECEL}, '{0, `OFS_JERK, 0, `RST_JERK},
			'{0, `OFS_MOVE_LEN, 0, `RST_MOVE_LEN}, '{0, `OFS_STATUS, 0, 0}, '{0, `OFS_CUR_SPEED, 0, 0},
			'{0, `OFS_STEP_COUNT, 0, 0}, '{0, `OFS_CTRL, 0, 0}, '{1, `OFS_STATUS, 32'hFFFFFFFF, 0},
			'{1, 8'h40, 32'h12345678, 0}, '{1, `OFS_JERK, 32'h1770, `JERK_MAX}, '{1, `OFS_JERK, 32'h1388, `JERK_MAX},
			'{1, `OFS_START_SPEED, 32'hFFFFFFFF, 32'hFFFFF}, '{1, `OFS_ACCEL, 32'h12345678, 32'h5678}};
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (i = 0; i < 16; i = i + 1)
		begin
			if (rows[i].w)
				bus(1'b1, rows[i].a, rows[i].d);
			bus(1'b0, rows[i].a, 32'h0);
			chk("register", rows[i].e, q);
		end
		// Flat move: restart while busy is ignored, ce low freezes stepping
		set_move(32'hF4240, 32'hF4240, 32'h4E20, 32'h0, 32'h14);
		go;
		while (steps < 32'h5) @(posedge hclk);
		bus(1'b1, `OFS_CTRL, 32'h1);
		ce <= 1'b0;
		@(posedge hclk);
		s0 = steps;
		repeat (500) @(posedge hclk);
		chk("frozen steps", s0, steps);
		ce <= 1'b1;
		poll;
		chk("flat steps", 32'h14, steps);
		bus(1'b0, `OFS_STEP_COUNT, 32'h0);
		chk("step count", 32'h14, q);
		bus(1'b0, `OFS_STATUS, 32'h0);
		chk("done", 32'h1, {31'h0, q[`STAT_DONE_BIT]});
		// Linear ramp gains ACCEL per tick from the starting speed
		set_move(32'h186A0, 32'hF4240, 32'h4E20, 32'h0, 32'h186A0);
		go;
		sample3;
		chk("start speed", 32'h1, {31'h0, s0 >= 32'h186A0});
		chk("linear rise", 32'h30D40, s1 - s0);
		chk("linear rise", 32'h30D40, s2 - s1);
		// S-curve: slower start, acceleration still climbing
		set_move(32'h186A0, 32'hF4240, 32'h4E20, 32'h64, 32'h186A0);
		go;
		bus(1'b0, `OFS_STATUS, 32'h0);
		chk("s-curve flag", 32'h1, {31'h0, q[`STAT_SCURVE_BIT]});
		sample3;
		chk("slow start", 32'h1, {31'h0, (s1 - s0) < 32'h30D40});
		chk("rising accel", 32'h1, {31'h0, (s2 - s1) > (s1 - s0)});
		// Jerk 100 on 20000 gives 20 steps/s per tick squared: 2000 over ten-tick spacing
		chk("jerk rate", 32'h1, {31'h0, (s2 - s1) - (s1 - s0) >= 32'h7CE && (s2 - s1) - (s1 - s0) <= 32'h7D1});
		// Long move cruises, short move turns straight to deceleration
		for (i = 0; i < 2; i = i + 1)
		begin
			set_move(32'h186A0, 32'hF4240, 32'h4E20, 32'h0, (i == 0) ? 32'hC8 : 32'hA);
			go;
			poll;
			chk("profile steps", (i == 0) ? 32'hC8 : 32'hA, steps);
			chk("cruise seen", (i == 0) ? 32'h1 : 32'h0, {31'h0, cr});
		end
		// Reset in mid-move
		go;
		repeat (200) @(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		chk("reset moving", 32'h0, {30'h0, moving, step_out});
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, `OFS_START_SPEED, 32'h0);
		chk("reset start speed", `RST_START_SPEED, q);
		stop_test;
	end
endmodule // step_rate_profile_generator_test
bind step_rate_profile_generator profile_checker chk_u
(
	.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
	.hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.step_out(step_out), .moving(moving)
);
